//--- core/mhb_consts.svh
`ifndef MHB_CONSTS_SVH
`define MHB_CONSTS_SVH
// timebase: one tick per millisecond at 40 MHz
`define MHB_CLK_PERIOD_NS  25
`define MHB_TICK_NS        1000000
`define MHB_TICK_CYCLES    (`MHB_TICK_NS / `MHB_CLK_PERIOD_NS)
// brake function selector codes
`define MHB_SEL_CLOSED     2'h0
`define MHB_SEL_SEQ        2'h1
`define MHB_SEL_OPEN       2'h2
`define MHB_SEL_SEQ_ROUTED 2'h3
// reset values of outputs
`define MHB_RST_BRAKE      1'b0
`define MHB_RST_MOTOR      1'b0
`endif

//--- core/mhb_pkg.sv
package mhb_pkg;
   // run and stop commands travel together
   typedef struct packed {
      logic on;
      logic ramp_stop_cmd;
      logic coast_stop_cmd;
      logic fast_stop_cmd;
   } mhb_cmd_t;

   // sequencer states
   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_EXCITE  = 3'b001,
      ST_OPENING = 3'b010,
      ST_RUN     = 3'b011,
      ST_DECEL   = 3'b100,
      ST_CLOSING = 3'b101
   } mhb_state_t;
endpackage : mhb_pkg

//--- core/mhb_sequencer.sv
`include "mhb_consts.svh"

// Behaviour
// - switch-on enables the motor; release follows the excitation interval.
// - the speed reference stays zero for the opening interval, then ramps.
// - ramp and fast stops compare setpoint and speed with the threshold.
// - setpoint below threshold starts the standstill monitoring timer.
// - measured speed below threshold starts the pulse suppression timer.
// - brake release drops when the first of those two timers expires.
// - the motor stays on for the closing interval after the brake closes.
// - a coast stop closes the brake at once, whatever the speed.
// - in sequence modes the motor is enabled whenever the brake is released.
// - selector: 0 closed, 1 sequence, 2 open, 3 sequence via routed input.
// - force-release acts unless force-close or a coast stop is set; force-close acts unconditionally; both idle low.
// - a status output reports whether the brake is open.
module mhb_sequencer #(
   parameter int TW = 16,                       // timer width in bits
   parameter int SW = 16,                       // speed width
   parameter int TICK_CYCLES = `MHB_TICK_CYCLES // cycles per tick
) (
   input  wire logic          mclk,                       // 40 MHz clock
   input  wire logic          rst,                        // async reset
   input  wire mhb_pkg::mhb_cmd_t cmd,                    // run and stops
   input  wire logic [1:0]    brake_function_select,      // selector
   input  wire logic          routed_release,             // mode 3 source
   input  wire logic          force_brake_release_src,    // force open
   input  wire logic          force_brake_close_src,      // force closed
   input  wire logic [TW-1:0] excitation_buildup_time,    // ticks
   input  wire logic [TW-1:0] brake_open_interval,        // ticks
   input  wire logic [TW-1:0] brake_close_interval,       // ticks
   input  wire logic [TW-1:0] standstill_monitor_time,    // ticks
   input  wire logic [TW-1:0] pulse_suppress_delay,       // ticks
   input  wire logic [SW-1:0] standstill_speed_threshold, // magnitude
   input  wire logic [SW-1:0] speed_setpoint,             // magnitude
   input  wire logic [SW-1:0] speed_actual,               // magnitude
   output logic               brake_release,              // 1 = open
   output logic               motor_enable,               // power stage
   output logic               speed_ref_enable,           // 0 holds zero
   output logic               brake_open_status           // status
);
   localparam int CW = $clog2(TICK_CYCLES + 1);

   mhb_pkg::mhb_state_t st_q, st_d;
   logic [CW-1:0] div_q, div_d;
   logic tick;
   logic rel_q, rel_d, men_q, men_d, sre_q, sre_d, sts_q, sts_d;
   logic cmd_edge, seq_mode, stop_any;
   mhb_pkg::mhb_cmd_t cmd_q;
   logic t_exc, t_open, t_close, t_ss, t_ps;
   logic sp_low, act_low;

   // timebase divider for all sequencing intervals
   always_comb begin
      div_d = div_q + CW'(1);
      if (div_q == CW'(TICK_CYCLES - 1)) begin
         div_d = '0;
      end
   end
   assign tick = (div_q == CW'(TICK_CYCLES - 1));

   // any new command edge restarts every timer
   assign cmd_edge = |(cmd & ~cmd_q);
   assign stop_any = cmd.ramp_stop_cmd | cmd.fast_stop_cmd;
   assign seq_mode = brake_function_select == `MHB_SEL_SEQ ||
                     brake_function_select == `MHB_SEL_SEQ_ROUTED;
   // comparisons run continuously while decelerating
   assign sp_low  = speed_setpoint < standstill_speed_threshold;
   assign act_low = speed_actual < standstill_speed_threshold;

   mhb_tick_timer #(.W(TW)) u_exc (
      .mclk(mclk), .rst(rst), .clr(cmd_edge),
      .run(st_q == mhb_pkg::ST_EXCITE),
      .tick(tick), .limit(excitation_buildup_time), .done(t_exc));
   mhb_tick_timer #(.W(TW)) u_open (
      .mclk(mclk), .rst(rst), .clr(cmd_edge),
      .run(st_q == mhb_pkg::ST_OPENING),
      .tick(tick), .limit(brake_open_interval), .done(t_open));
   mhb_tick_timer #(.W(TW)) u_close (
      .mclk(mclk), .rst(rst), .clr(cmd_edge),
      .run(st_q == mhb_pkg::ST_CLOSING),
      .tick(tick), .limit(brake_close_interval), .done(t_close));
   // standstill monitor starts when setpoint drops below threshold
   mhb_tick_timer #(.W(TW)) u_ss (
      .mclk(mclk), .rst(rst), .clr(cmd_edge),
      .run(st_q == mhb_pkg::ST_DECEL && sp_low),
      .tick(tick), .limit(standstill_monitor_time), .done(t_ss));
   // pulse suppression delay starts when speed drops below threshold
   mhb_tick_timer #(.W(TW)) u_ps (
      .mclk(mclk), .rst(rst), .clr(cmd_edge),
      .run(st_q == mhb_pkg::ST_DECEL && act_low),
      .tick(tick), .limit(pulse_suppress_delay), .done(t_ps));

   // sequencer next state; coast stop overrides everything
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         mhb_pkg::ST_OFF: begin
            if (cmd.on && !stop_any && !cmd.coast_stop_cmd) begin
               st_d = mhb_pkg::ST_EXCITE;
            end
         end
         mhb_pkg::ST_EXCITE: begin
            if (t_exc) begin
               st_d = mhb_pkg::ST_OPENING;
            end
         end
         mhb_pkg::ST_OPENING: begin
            if (t_open) begin
               st_d = mhb_pkg::ST_RUN;
            end
         end
         mhb_pkg::ST_RUN: begin
            if (stop_any) begin
               st_d = mhb_pkg::ST_DECEL;
            end
         end
         mhb_pkg::ST_DECEL: begin
            if (t_ss || t_ps) begin
               st_d = mhb_pkg::ST_CLOSING;
            end
         end
         mhb_pkg::ST_CLOSING: begin
            if (t_close) begin
               st_d = mhb_pkg::ST_OFF;
            end
         end
         default: st_d = mhb_pkg::ST_OFF;
      endcase
      // a stop during start-up goes straight to deceleration
      if (stop_any && (st_q == mhb_pkg::ST_EXCITE ||
                       st_q == mhb_pkg::ST_OPENING)) begin
         st_d = mhb_pkg::ST_DECEL;
      end
      if (cmd.coast_stop_cmd) begin
         st_d = mhb_pkg::ST_OFF;
      end
   end

   // outputs, all registered
   always_comb begin
      rel_d = st_d == mhb_pkg::ST_OPENING || st_d == mhb_pkg::ST_RUN ||
              st_d == mhb_pkg::ST_DECEL;
      // routed source gates the sequence in mode 3
      if (brake_function_select == `MHB_SEL_SEQ_ROUTED) begin
         rel_d = rel_d & routed_release;
      end
      if (brake_function_select == `MHB_SEL_CLOSED) begin
         rel_d = 1'b0;
      end
      if (brake_function_select == `MHB_SEL_OPEN) begin
         rel_d = 1'b1;
      end
      // close wins over release: failing safe holds the load
      if (force_brake_release_src) begin
         rel_d = 1'b1;
      end
      if (force_brake_close_src || cmd.coast_stop_cmd) begin
         rel_d = 1'b0;
      end
      // motor stays on while brake released in sequence modes
      men_d = st_d != mhb_pkg::ST_OFF || (seq_mode && rel_d);
      if (cmd.coast_stop_cmd) begin
         men_d = 1'b0;
      end
      sre_d = st_d == mhb_pkg::ST_RUN;
      sts_d = rel_d;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q  <= mhb_pkg::ST_OFF;
         div_q <= '0;
         cmd_q <= '0;
         rel_q <= `MHB_RST_BRAKE;
         men_q <= `MHB_RST_MOTOR;
         sre_q <= 1'b0;
         sts_q <= `MHB_RST_BRAKE;
      end else begin
         st_q  <= st_d;
         div_q <= div_d;
         cmd_q <= cmd;
         rel_q <= rel_d;
         men_q <= men_d;
         sre_q <= sre_d;
         sts_q <= sts_d;
      end
   end

   assign brake_release     = rel_q;
   assign motor_enable      = men_q;
   assign speed_ref_enable  = sre_q;
   assign brake_open_status = sts_q;

   // ---- assertions ----
   property p_exc_open;
      @(posedge mclk) disable iff (rst)
      (st_q == mhb_pkg::ST_EXCITE && t_exc && !stop_any &&
       !cmd.coast_stop_cmd) |=> (st_q == mhb_pkg::ST_OPENING);
   endproperty
   a_exc_open: assert property (p_exc_open)
      else $error("no open after excite");

   property p_hold_ref;
      @(posedge mclk) disable iff (rst)
      // the reference output is registered with the state, so it is checked
      // in the same cycle; the ramp starts only in the first run cycle
      (st_q == mhb_pkg::ST_OPENING) |-> !speed_ref_enable;
   endproperty
   a_hold_ref: assert property (p_hold_ref)
      else $error("ref released early");

   property p_first_timer;
      @(posedge mclk) disable iff (rst)
      (st_q == mhb_pkg::ST_DECEL && (t_ss || t_ps) && !cmd.coast_stop_cmd)
      |=> (st_q == mhb_pkg::ST_CLOSING);
   endproperty
   a_first_timer: assert property (p_first_timer)
      else $error("no close");

   property p_ss_start;
      @(posedge mclk) disable iff (rst)
      (st_q == mhb_pkg::ST_DECEL && !sp_low && !act_low)
      |-> !(t_ss || t_ps) ||
      standstill_monitor_time == '0 || pulse_suppress_delay == '0;
   endproperty
   a_ss_start: assert property (p_ss_start)
      else $error("timer w/o low");

   property p_close_motor;
      @(posedge mclk) disable iff (rst)
      (st_q == mhb_pkg::ST_CLOSING && !t_close && !cmd.coast_stop_cmd)
      |=> motor_enable;
   endproperty
   a_close_motor: assert property (p_close_motor)
      else $error("motor off early");

   property p_coast;
      @(posedge mclk) disable iff (rst)
      cmd.coast_stop_cmd |=> !brake_release && !motor_enable;
   endproperty
   a_coast: assert property (p_coast)
      else $error("coast kept brake open");

   property p_motor_rel;
      @(posedge mclk) disable iff (rst)
      (seq_mode && brake_release) |-> motor_enable;
   endproperty
   a_motor_rel: assert property (p_motor_rel)
      else $error("released w/o motor");

   property p_force_close;
      @(posedge mclk) disable iff (rst)
      force_brake_close_src |=> !brake_release;
   endproperty
   a_force_close: assert property (p_force_close)
      else $error("force close");

   property p_status;
      @(posedge mclk) disable iff (rst)
      brake_open_status == brake_release;
   endproperty
   a_status: assert property (p_status)
      else $error("status mismatch");

   c_run:   cover property (@(posedge mclk) st_q == mhb_pkg::ST_RUN);
   c_close: cover property (@(posedge mclk)
      st_q == mhb_pkg::ST_CLOSING ##1 st_q == mhb_pkg::ST_OFF);
   c_coast: cover property (@(posedge mclk)
                            st_q == mhb_pkg::ST_RUN && cmd.coast_stop_cmd);
endmodule : mhb_sequencer

//--- core/mhb_tick_timer.sv
`include "mhb_consts.svh"

// interval counter in ticks; restarts on clr, expires once count reached
module mhb_tick_timer #(
   parameter int W = 16
) (
   input  wire logic         mclk,   // system clock
   input  wire logic         rst,    // async reset, high
   input  wire logic         clr,    // restart from zero
   input  wire logic         run,    // count while high
   input  wire logic         tick,   // timebase pulse
   input  wire logic [W-1:0] limit,  // interval in ticks
   output logic              done    // interval elapsed, level
);
   logic [W-1:0] cnt_q, cnt_d;

   // saturate at limit so done holds until cleared
   always_comb begin
      cnt_d = cnt_q;
      if (clr || !run) begin
         cnt_d = '0;
      end else if (tick && cnt_q < limit) begin
         cnt_d = cnt_q + W'(1);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign done = run && !clr && (cnt_q >= limit);
endmodule : mhb_tick_timer

//--- testbench/mhb_drive_model.sv
// stand-in for the brake and motor shaft on the far side of the block
module mhb_drive_model (
   input  wire logic        mclk,             // system clock
   input  wire logic        rst,              // async reset, high
   input  wire logic        motor_enable,     // power stage on
   input  wire logic        brake_release,    // 1 = brake open
   input  wire logic        speed_ref_enable, // 0 holds reference at zero
   input  wire logic [15:0] speed_setpoint,   // wanted magnitude
   output logic      [15:0] speed_actual      // measured magnitude
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] tgt;

   // a held reference pulls the shaft down even if the setpoint is high
   always_comb begin
      tgt = speed_ref_enable ? speed_setpoint : 16'h0000;
   end

   // one step per cycle so the two stop timers really race;
   // a closed brake clamps the shaft, an unpowered open shaft coasts
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         speed_actual <= 16'h0000;
      else if (!brake_release)
         speed_actual <= 16'h0000;
      else if (motor_enable && speed_actual < tgt)
         speed_actual <= speed_actual + 16'h0001;
      else if (motor_enable && speed_actual > tgt)
         speed_actual <= speed_actual - 16'h0001;
   end
endmodule : mhb_drive_model

//--- testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 4; // short tick keeps the run brief
   logic              mclk, rst, routed_release;
   logic              force_brake_release_src, force_brake_close_src;
   mhb_pkg::mhb_cmd_t cmd;
   logic [1:0]        brake_function_select;
   logic [15:0]       excitation_buildup_time, brake_open_interval;
   logic [15:0]       brake_close_interval, standstill_monitor_time;
   logic [15:0]       pulse_suppress_delay, standstill_speed_threshold;
   logic [15:0]       speed_setpoint, speed_actual;
   logic              brake_release, motor_enable;
   logic              speed_ref_enable, brake_open_status;
   logic [3:0]        o;
   int                n_fail = 0, total_checks = 0, cyc = 0;

   assign o = {brake_release, motor_enable, speed_ref_enable,
               brake_open_status};

   mhb_sequencer #(.TICK_CYCLES(TC)) i_mhb_sequencer (
      .mclk, .rst, .cmd, .brake_function_select, .routed_release,
      .force_brake_release_src, .force_brake_close_src,
      .excitation_buildup_time, .brake_open_interval,
      .brake_close_interval, .standstill_monitor_time,
      .pulse_suppress_delay, .standstill_speed_threshold,
      .speed_setpoint, .speed_actual, .brake_release, .motor_enable,
      .speed_ref_enable, .brake_open_status);

   mhb_drive_model i_mhb_drive_model (
      .mclk, .rst, .motor_enable, .brake_release, .speed_ref_enable,
      .speed_setpoint, .speed_actual);

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // hang guard: the whole run needs well under 3000 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : chk

   // wait at falling edges until the outputs show a pattern
   task automatic wait_o(input logic [3:0] exp, output int n);
      n = 0;
      while (o !== exp && n < 400) begin
         @(negedge mclk);
         n++;
      end
      chk({12'h0000, o}, {12'h0000, exp});
   endtask : wait_o

   task automatic win(input int n, input int lo, input int hi);
      chk({15'h0000, n >= lo && n <= hi}, 16'h0001);
   endtask : win

   // k ticks measured in cycles; tick phase is unknown to the bench
   task automatic tw(input int n, input int k);
      win(n, (k - 1) * TC, (k + 1) * TC + 3);
   endtask : tw

   task automatic do_reset;
      rst = 1'b1;
      cmd = '0;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
   endtask : do_reset

   // switch on, then time excitation and opening intervals
   task automatic switch_on;
      int n;
      cmd.on = 1'b1;
      @(negedge mclk);
      chk({12'h0000, o}, 16'h0004);
      wait_o(4'b1101, n);
      tw(n + 1, 3);
      wait_o(4'b1111, n);
      tw(n, 4);
   endtask : switch_on

   // run up, stop, time brake drop from the stop and motor off after it
   task automatic stop_run(input logic fast, input logic [15:0] sp0,
                           input logic [15:0] sp1, output int n);
      int m;
      speed_setpoint = sp0;
      switch_on();
      repeat (120) @(negedge mclk);
      cmd.ramp_stop_cmd = !fast;
      cmd.fast_stop_cmd = fast;
      speed_setpoint = sp1;
      @(negedge mclk);
      chk({12'h0000, o}, 16'h000d);
      wait_o(4'b0100, n);
      n++;
      wait_o(4'b0000, m);
      tw(m, 5);
      cmd = '0;
      @(negedge mclk);
   endtask : stop_run

   initial begin
      int n;
      brake_function_select = 2'h1;
      routed_release = 1'b0;
      force_brake_release_src = 1'b0;
      force_brake_close_src = 1'b0;
      excitation_buildup_time = 16'h0003;
      brake_open_interval = 16'h0004;
      brake_close_interval = 16'h0005;
      standstill_monitor_time = 16'h000a;
      pulse_suppress_delay = 16'h0002;
      standstill_speed_threshold = 16'h0014;
      speed_setpoint = 16'h0000;
      do_reset();
      chk({12'h0000, o}, 16'h0000);
      // low setpoint at once, shaft still fast: monitor timer wins
      stop_run(1'b0, 16'h0064, 16'h0005, n);
      win(n, 36, 48);
      // setpoint just under, shaft slow: suppression timer wins
      stop_run(1'b1, 16'h001e, 16'h0013, n);
      win(n, 14, 30);
      $display("stop sequences done");
      switch_on();
      cmd.coast_stop_cmd = 1'b1;
      @(negedge mclk);
      chk({12'h0000, o}, 16'h0000);
      $display("coast stop done");
      brake_function_select = 2'h0;
      do_reset();
      cmd.on = 1'b1;
      repeat (40) @(negedge mclk);
      chk({15'h0000, brake_release}, 16'h0000);
      brake_function_select = 2'h2;
      do_reset();
      @(negedge mclk);
      chk({12'h0000, o}, 16'h0009);
      brake_function_select = 2'h3;
      do_reset();
      cmd.on = 1'b1;
      repeat (40) @(negedge mclk);
      chk({15'h0000, brake_release}, 16'h0000);
      routed_release = 1'b1;
      repeat (2) @(negedge mclk);
      chk({15'h0000, brake_release}, 16'h0001);
      $display("selector modes done");
      brake_function_select = 2'h1;
      do_reset();
      force_brake_release_src = 1'b1;
      repeat (2) @(negedge mclk);
      chk({15'h0000, brake_release}, 16'h0001);
      force_brake_close_src = 1'b1;
      repeat (2) @(negedge mclk);
      chk({15'h0000, brake_release}, 16'h0000);
      $display("force inputs done");
      give_verdict();
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
endmodule : testbench
